// ===== design/acd_defs.svh
// constants for the chop, standby and detect controller
// assumes a 50 MHz ref_clk and a byte-addressed register bus
`ifndef ACD_DEFS_SVH
`define ACD_DEFS_SVH
`define ACD_NCH 6
`define ACD_DW 24
`define ACD_CLK_NS 20
// register byte offsets
`define ACD_OFS_CTRL 8'h00
`define ACD_OFS_DET 8'h04
`define ACD_OFS_THR_HI 8'h08
`define ACD_OFS_THR_LO 8'h0C
`define ACD_OFS_CMD 8'h10
`define ACD_OFS_STAT 8'h14
`define ACD_OFS_RESULT 8'h18
// control fields: chop [0], delay [7:4], power [9:8], osr code [14:12], channels [21:16]
`define ACD_CTRL_MASK 32'h003F_73F1
`define ACD_CTRL_RST 32'h003F_3000
// detect fields: hits [2:0], samples [6:4], all channels [8], enable [9]
`define ACD_DET_MASK 32'h0000_0377
`define ACD_DET_RST 32'h0000_0000
`define ACD_CMD_STANDBY 16'h0022
`define ACD_CMD_WAKEUP 16'h0033
`define ACD_START_TICKS 17'h0_002C
`define ACD_WAKE_TICKS 17'h0_0008
`define ACD_CONVERSION_READY_FLAG_LOW 3'h4
`define ACD_RST_PULSE_NS 2000
`define ACD_RST_CYC ((`ACD_RST_PULSE_NS + `ACD_CLK_NS - 1) / `ACD_CLK_NS)
`endif

// ===== design/acd_pkg.sv
// types for the chop, standby and detect controller
// assumes acd_defs.svh on the include path
`include "acd_defs.svh"
package acd_pkg;
  typedef enum logic [6:0] {
    ST_START = 7'h01,
    ST_SETTLE = 7'h02,
    ST_CONV = 7'h04,
    ST_STBY = 7'h08,
    ST_WAKE = 7'h10,
    ST_DET = 7'h20,
    ST_RST = 7'h40
  } acd_mode_e;

  typedef struct packed {
    acd_mode_e st;
    logic [2:0] mclkS;
    logic [2:0] syncS;
    logic [2:0] oscS;
    logic [31:0] ctrl;
    logic [31:0] det;
    logic [23:0] thr;
    logic [16:0] cnt;
    logic [15:0] lowCnt;
    logic pol;
    logic haveFirst;
    logic filtRst;
    logic [23:0] prevConv;
    logic [23:0] result;
    logic [2:0] drdyCnt;
    logic [11:0] sampCnt;
    logic [`ACD_NCH*4-1:0] hits;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } acd_state_s;
endpackage : acd_pkg

// ===== design/acd_chop_detect.sv
// chop conversion sequencer, standby and current-detect controller
// assumes an AXI4-Lite master on ref_clk and filter results on ref_clk
// Behaviour
// R1: chop on: output combines two opposite-polarity conversions, cancelling offset.
// R2: normal polarity first, then inverted, alternating every conversion.
// R3: each output is the mean of a sliding pair of conversions.
// R4: filter reset on each swap; three conversion periods per settled result.
// R5: settling delay after every swap, set by a four-bit delay field.
// R6: delay code k gives two to the power k+1 modulator periods.
// R7: steady result every delay plus three times oversampling ratio periods.
// R8: falling edge on ready flag for each new chop result.
// R9: chop restarts on sync pin falling edge or ratio change.
// R10: first result after restart takes two full cycles plus 44 periods.
// R11: chop on forces phase calibration off.
// R12: three power levels selected by a two-bit field.
// R13: standby command disables channels, keeps registers; host stops clock.
// R14: wakeup command leaves standby; sampling starts after 8 periods.
// R15: short sync low pulse enters detect, only from standby.
// R16: sync held low beyond reset width resets until released.
// R17: detect converts on internal oscillator, compares absolute value to threshold.
// R18: enough hits give ready falling edge and return to standby.
// R19: 24-bit threshold split over high and low registers.
// R20: three-bit field sets samples per pass, 128 to 3584.
// R21: three-bit field sets hits needed for detection.
// R22: hit means strictly above threshold, counted per enabled channel.
// R23: all-channels bit: every enabled channel must meet, else any one.
// R24: detect enable bit turns detection on or off.
// R25: serial peripheral in mode 1, handled outside this block.
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "acd_defs.svh"
module acd_chop_detect #(
  parameter int RST_CYC = `ACD_RST_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic masterClk,
  input wire logic syncRstN,
  input wire logic oscClk,
  input wire logic [23:0] filtData,
  input wire logic [`ACD_NCH*24-1:0] detData,
  output logic convReadyN,
  output logic chopInvert,
  output logic filterReset,
  output logic phaseCalOff,
  output logic [1:0] powerLevel,
  output logic modRun,
  output logic standbyPowerDown,
  output logic detectOscOn
);
  acd_pkg::acd_state_s r;
  acd_pkg::acd_state_s n;
  logic modTick, oscTick, syncFall, syncRise, wrFire, rdFire, detMet;
  logic [15:0] oversampling_ratio;
  logic [16:0] convLen, delayLen;
  logic [11:0] passLen;
  logic [3:0] hitNeed;
  logic [`ACD_NCH-1:0] chEn, met;
  logic [`ACD_NCH*4-1:0] hitsUpd;
  logic [23:0] avg;
  logic [24:0] diff;

  // ===========================================================
  // helpers
  // byte-lane merge so partial writes leave other fields intact
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s, input logic [31:0] m);
    logic [31:0] l;
    l = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return ((d & l) | (o & ~l)) & m;
  endfunction : merge

  // samples per detection pass, 128 up to 3584, indexed by the length code
  localparam logic [7:0][11:0] PASS_LEN = {12'hE00, 12'h800, 12'h600, 12'h400, 12'h300,
                                           12'h200, 12'h100, 12'h080};

  // ===========================================================
  // decoded fields and edges
  // edges only from the second synchroniser stage onward
  assign modTick = r.mclkS[1] & ~r.mclkS[2];
  assign oscTick = r.oscS[1] & ~r.oscS[2];
  assign syncFall = r.syncS[2] & ~r.syncS[1];
  assign syncRise = ~r.syncS[2] & r.syncS[1];
  assign oversampling_ratio = 16'h0080 << r.ctrl[14:12];
  assign convLen = r.ctrl[0] ? 17'({1'b0, oversampling_ratio} + {oversampling_ratio, 1'b0}) : {1'b0, oversampling_ratio}; // [R7]
  assign delayLen = 17'h0_0001 << ({1'b0, r.ctrl[7:4]} + 5'h01); // [R5] [R6]
  assign passLen = PASS_LEN[r.det[6:4]]; // [R20]
  assign hitNeed = {1'b0, r.det[2:0]} + 4'h1; // [R21]
  assign chEn = r.ctrl[21:16];
  // previous conversion normal polarity: prev minus current, else reverse
  assign diff = r.pol ? 25'({r.prevConv[23], r.prevConv} - {filtData[23], filtData})
                      : 25'({filtData[23], filtData} - {r.prevConv[23], r.prevConv});
  assign avg = diff[24:1]; // [R1] [R3]

  // ===========================================================
  // per-channel threshold compare and hit counting
  for (genvar c = 0; c < `ACD_NCH; c++)
  begin : g_ch
    logic [23:0] d, mag;
    logic over;
    assign d = detData[24*c +: 24];
    assign mag = d[23] ? 24'(-d) : d; // [R17]
    assign over = chEn[c] && (mag > r.thr); // [R22] [R19]
    assign hitsUpd[4*c +: 4] = (over && r.hits[4*c +: 4] != 4'hF)
                               ? r.hits[4*c +: 4] + 4'h1 : r.hits[4*c +: 4];
    assign met[c] = chEn[c] && (hitsUpd[4*c +: 4] >= hitNeed);
  end
  // all-channels needs every enabled one, otherwise any one
  assign detMet = r.det[8] ? ((&(met | ~chEn)) && (|chEn)) : (|met); // [R23]

  // ===========================================================
  // bus handshakes and outputs
  assign wrFire = awvalid && wvalid && !r.bvalid;
  assign rdFire = arvalid && !r.rvalid;
  assign awready = wrFire;
  assign wready = wrFire;
  assign arready = !r.rvalid;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign rvalid = r.rvalid;
  assign rresp = r.rresp;
  assign rdata = r.rdata;
  assign convReadyN = (r.drdyCnt == 3'h0); // [R8] [R18]
  assign chopInvert = r.pol; // [R2]
  assign filterReset = r.filtRst;
  assign phaseCalOff = r.ctrl[0]; // [R11]
  assign powerLevel = r.ctrl[9:8]; // [R12]
  assign modRun = r.st[0] | r.st[1] | r.st[2];
  assign standbyPowerDown = r.st[3] | r.st[4] | r.st[5]; // [R13]
  assign detectOscOn = r.st[5]; // [R17]

  // ===========================================================
  // next-state logic
  always_comb
  begin
    logic osrChg;
    logic isCmd;
    logic [31:0] nv;
    osrChg = 1'b0;
    isCmd = 1'b0;
    nv = 32'h0000_0000;
    n = r;
    n.filtRst = 1'b0;
    n.mclkS = {r.mclkS[1:0], masterClk};
    n.syncS = {r.syncS[1:0], syncRstN};
    n.oscS = {r.oscS[1:0], oscClk};
    if (r.drdyCnt != 3'h0) n.drdyCnt = r.drdyCnt - 3'h1;
    // register writes
    if (r.bvalid && bready) n.bvalid = 1'b0;
    if (wrFire)
    begin
      n.bvalid = 1'b1;
      n.bresp = 2'b00;
      unique case (awaddr)
        `ACD_OFS_CTRL:
        begin
          nv = merge(r.ctrl, wdata, wstrb, `ACD_CTRL_MASK);
          osrChg = nv[14:12] != r.ctrl[14:12];
          n.ctrl = nv;
        end
        `ACD_OFS_DET: n.det = merge(r.det, wdata, wstrb, `ACD_DET_MASK); // [R24]
        `ACD_OFS_THR_HI: n.thr[23:16] = wstrb[0] ? wdata[7:0] : r.thr[23:16]; // [R19]
        `ACD_OFS_THR_LO: n.thr[15:0] = 16'(merge(32'(r.thr[15:0]), wdata, wstrb, '1)); // [R19]
        `ACD_OFS_CMD: isCmd = 1'b1;
        `ACD_OFS_STAT, `ACD_OFS_RESULT: ;
        default: n.bresp = 2'b10;
      endcase
    end
    // register reads
    if (r.rvalid && rready) n.rvalid = 1'b0;
    if (rdFire)
    begin
      n.rvalid = 1'b1;
      n.rresp = 2'b00;
      unique case (araddr)
        `ACD_OFS_CTRL: n.rdata = r.ctrl;
        `ACD_OFS_DET: n.rdata = r.det;
        `ACD_OFS_THR_HI: n.rdata = {24'h00_0000, r.thr[23:16]};
        `ACD_OFS_THR_LO: n.rdata = {16'h0000, r.thr[15:0]};
        `ACD_OFS_CMD: n.rdata = 32'h0000_0000;
        `ACD_OFS_STAT: n.rdata = {20'h0_0000, r.ctrl[0], r.haveFirst, r.pol, 2'b00, r.st};
        `ACD_OFS_RESULT: n.rdata = {{8{r.result[23]}}, r.result};
        default:
        begin
          n.rdata = 32'h0000_0000;
          n.rresp = 2'b10;
        end
      endcase
    end
    // sync pin low time, used to tell a reset from a pulse
    if (r.syncS[1]) n.lowCnt = 16'h0000;
    else if (r.lowCnt != 16'hFFFF) n.lowCnt = r.lowCnt + 16'h0001;
    // mode machine
    unique case (r.st)
      acd_pkg::ST_START, acd_pkg::ST_SETTLE, acd_pkg::ST_CONV:
      begin
        if (modTick) n.cnt = r.cnt + 17'h0_0001;
        if (r.st == acd_pkg::ST_START && modTick && r.cnt == `ACD_START_TICKS - 17'h0_0001)
        begin
          n.cnt = 17'h0_0000;
          n.st = r.ctrl[0] ? acd_pkg::ST_SETTLE : acd_pkg::ST_CONV; // [R10]
        end
        if (r.st == acd_pkg::ST_SETTLE && modTick && r.cnt == delayLen - 17'h0_0001)
        begin
          n.cnt = 17'h0_0000;
          n.st = acd_pkg::ST_CONV; // [R5]
        end
        if (r.st == acd_pkg::ST_CONV && modTick && r.cnt == convLen - 17'h0_0001)
        begin
          n.cnt = 17'h0_0000;
          if (r.ctrl[0])
          begin
            // swap polarity, clear filter, then settle again
            n.prevConv = filtData;
            n.haveFirst = 1'b1;
            n.pol = ~r.pol; // [R2]
            n.filtRst = 1'b1; // [R4]
            n.st = acd_pkg::ST_SETTLE;
            if (r.haveFirst)
            begin
              n.result = avg; // [R3]
              n.drdyCnt = `ACD_CONVERSION_READY_FLAG_LOW; // [R8]
            end
          end
          else
          begin
            n.result = filtData;
            n.drdyCnt = `ACD_CONVERSION_READY_FLAG_LOW;
          end
        end
        // restart all channels together
        if (r.ctrl[0] && (syncFall || osrChg)) // [R9]
        begin
          n.st = acd_pkg::ST_START;
          n.cnt = 17'h0_0000;
          n.pol = 1'b0;
          n.haveFirst = 1'b0;
          n.filtRst = 1'b1;
        end
        if (isCmd && wdata[15:0] == `ACD_CMD_STANDBY) n.st = acd_pkg::ST_STBY; // [R13]
      end
      acd_pkg::ST_STBY:
      begin
        n.cnt = 17'h0_0000;
        n.pol = 1'b0;
        n.filtRst = r.pol; // [R4] polarity back to normal also clears the filter
        n.haveFirst = 1'b0;
        if (isCmd && wdata[15:0] == `ACD_CMD_WAKEUP) n.st = acd_pkg::ST_WAKE; // [R14]
        // short pulse only; a long one becomes a reset below
        if (syncRise && r.det[9] && r.lowCnt < 16'(RST_CYC)) // [R15] [R24]
        begin
          n.st = acd_pkg::ST_DET;
          n.sampCnt = 12'h000;
          n.hits = '0;
        end
      end
      acd_pkg::ST_WAKE:
      begin
        if (modTick) n.cnt = r.cnt + 17'h0_0001;
        if (modTick && r.cnt == `ACD_WAKE_TICKS - 17'h0_0001) // [R14]
        begin
          n.cnt = 17'h0_0000;
          n.st = r.ctrl[0] ? acd_pkg::ST_SETTLE : acd_pkg::ST_CONV;
        end
      end
      acd_pkg::ST_DET:
      begin
        if (oscTick)
        begin
          n.hits = hitsUpd;
          n.sampCnt = r.sampCnt + 12'h001;
          if (detMet) // [R18]
          begin
            n.drdyCnt = `ACD_CONVERSION_READY_FLAG_LOW;
            n.st = acd_pkg::ST_STBY;
          end
          else if (r.sampCnt == passLen - 12'h001) // [R20]
          begin
            n.sampCnt = 12'h000;
            n.hits = '0;
          end
        end
        if (!r.det[9]) n.st = acd_pkg::ST_STBY; // [R24]
      end
      acd_pkg::ST_RST:
      begin
        // registers back to defaults once the pin is released
        if (r.syncS[1]) // [R16]
        begin
          n.ctrl = `ACD_CTRL_RST;
          n.det = `ACD_DET_RST;
          n.thr = 24'h00_0000;
          n.result = 24'h00_0000;
          n.st = acd_pkg::ST_START;
          n.cnt = 17'h0_0000;
          n.pol = 1'b0;
          n.haveFirst = 1'b0;
          n.filtRst = r.pol; // [R4]
        end
      end
    endcase
    if (r.st != acd_pkg::ST_RST && !r.syncS[1] && r.lowCnt >= 16'(RST_CYC)) // [R16]
    begin
      n.st = acd_pkg::ST_RST;
      n.drdyCnt = 3'h0;
    end
  end

  // ===========================================================
  // state register; synchronisers idle high for the sync pin
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.st <= acd_pkg::ST_START;
      r.syncS <= 3'h7;
      r.ctrl <= `ACD_CTRL_RST;
      r.det <= `ACD_DET_RST;
    end
    else
    begin
      r <= n;
    end
  end

  // ===========================================================
  // checks
  sequence s_convEnd;
    r.st == acd_pkg::ST_CONV && modTick && r.cnt == convLen - 17'h0_0001 && r.ctrl[0];
  endsequence
  property p_polSwap;
    @(posedge ref_clk) disable iff (sys_rst)
    s_convEnd and (!syncFall && wrFire == 1'b0) |=> chopInvert != $past(chopInvert) && filterReset;
  endproperty
  a_polSwap: assert property (p_polSwap) else $error("polarity not swapped"); // [R2]
  property p_filtOnSwap;
    @(posedge ref_clk) disable iff (sys_rst)
    $changed(chopInvert) |-> filterReset;
  endproperty
  a_filtOnSwap: assert property (p_filtOnSwap) else $error("swap without filter reset"); // [R4]
  property p_settleBound;
    @(posedge ref_clk) disable iff (sys_rst)
    r.st == acd_pkg::ST_SETTLE |-> r.cnt < delayLen;
  endproperty
  a_settleBound: assert property (p_settleBound) else $error("settle overran"); // [R5]
  property p_readyFall;
    @(posedge ref_clk) disable iff (sys_rst)
    $fell(convReadyN) |-> $past(r.st) == acd_pkg::ST_DET || $past(r.haveFirst) || !$past(r.ctrl[0]);
  endproperty
  a_readyFall: assert property (p_readyFall) else $error("ready without result"); // [R8]
  property p_phaseOff;
    @(posedge ref_clk) disable iff (sys_rst)
    r.ctrl[0] |-> phaseCalOff;
  endproperty
  a_phaseOff: assert property (p_phaseOff) else $error("phase cal not forced off"); // [R11]
  property p_standby;
    @(posedge ref_clk) disable iff (sys_rst)
    wrFire && awaddr == `ACD_OFS_CMD && wdata[15:0] == `ACD_CMD_STANDBY && modRun |=>
      (r.st == acd_pkg::ST_STBY || r.st == acd_pkg::ST_RST) && r.ctrl == $past(r.ctrl);
  endproperty
  a_standby: assert property (p_standby) else $error("standby still running"); // [R13]
  property p_wakeBound;
    @(posedge ref_clk) disable iff (sys_rst)
    r.st == acd_pkg::ST_WAKE |-> r.cnt < `ACD_WAKE_TICKS && !modRun;
  endproperty
  a_wakeBound: assert property (p_wakeBound) else $error("wake wait wrong"); // [R14]
  sequence s_detHit;
    r.st == acd_pkg::ST_DET && oscTick && detMet && !(!r.syncS[1] && r.lowCnt >= 16'(RST_CYC));
  endsequence
  property p_detNotify;
    @(posedge ref_clk) disable iff (sys_rst)
    s_detHit |=> r.st == acd_pkg::ST_STBY && $fell(convReadyN);
  endproperty
  a_detNotify: assert property (p_detNotify) else $error("detect not notified"); // [R18]
  property p_resetHold;
    @(posedge ref_clk) disable iff (sys_rst)
    r.st == acd_pkg::ST_RST && !r.syncS[1] |=> r.st == acd_pkg::ST_RST;
  endproperty
  a_resetHold: assert property (p_resetHold) else $error("left reset early"); // [R16]
endmodule : acd_chop_detect

// ===== test/acd_front_model.sv
// stand-in for the far side: master clock, internal oscillator, filter output
// assumes the bench gates the master clock and the design reports polarity
`timescale 1ns/1ps
module acd_front_model #(
  parameter logic [23:0] SIG = 24'h00_03E8,
  parameter logic [23:0] OFS = 24'h00_0100
) (
  input wire logic clkRun,
  input wire logic oscRun,
  input wire logic chopInvert,
  output logic masterClk,
  output logic oscClk,
  output logic [23:0] filtData
);
  // ==========================================
  // clocks
  // master clock parks low when the host stops it, phase unrelated to ref_clk
  initial
  begin
    masterClk = 1'b0;
    #7;
    forever
    begin
      #80;
      masterClk = clkRun ? ~masterClk : 1'b0;
    end
  end
  // oscillator only runs while detection is active
  initial
  begin
    oscClk = 1'b0;
    forever
    begin
      #200;
      oscClk = oscRun ? ~oscClk : 1'b0;
    end
  end
  // offset plus or minus signal, so only the chop mean cancels the offset
  assign filtData = chopInvert ? OFS - SIG : OFS + SIG;
endmodule : acd_front_model

// ===== test/tb_adc_chop_standby_detect_control.sv
// bench for the chop, standby and detect controller over its register bus
// assumes acd_defs.svh on the include path and the front model beside it
`timescale 1ns/1ps
`include "acd_defs.svh"
module tb_adc_chop_standby_detect_control;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, powerLevel;
  logic [31:0] rdata, rv;
  logic [1:0] rs;
  logic masterClk, oscClk, convReadyN, chopInvert, filterReset, phaseCalOff;
  logic modRun, standbyPowerDown, detectOscOn, p;
  logic syncRstN = 1'b1, clkRun = 1'b1;
  logic [23:0] filtData;
  logic [`ACD_NCH*24-1:0] detData = '0;
  int failures = 0, nChecks = 0, ticks = 0, oscEdges = 0, nFr = 0, nFall = 0, t0, e;

  acd_chop_detect #(.RST_CYC(8)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .masterClk(masterClk), .syncRstN(syncRstN),
    .oscClk(oscClk), .filtData(filtData), .detData(detData), .convReadyN(convReadyN),
    .chopInvert(chopInvert), .filterReset(filterReset), .phaseCalOff(phaseCalOff),
    .powerLevel(powerLevel), .modRun(modRun), .standbyPowerDown(standbyPowerDown),
    .detectOscOn(detectOscOn));
  acd_front_model fm (.clkRun(clkRun), .oscRun(detectOscOn), .chopInvert(chopInvert),
    .masterClk(masterClk), .oscClk(oscClk), .filtData(filtData));

  // ==========================================
  // clock and event counters
  always #10 ref_clk = ~ref_clk;
  always @(posedge masterClk) ticks++;
  always @(posedge oscClk) oscEdges++;
  always @(negedge convReadyN) nFall++;
  // counted on ref_clk so a one-cycle pulse is seen exactly once
  always @(posedge ref_clk)
    if (filterReset === 1'b1)
      nFr++;

  // ==========================================
  // compare helpers
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    nChecks++;
    if (g !== x)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
      failures++;
    end
  endtask : chk
  // tick counts carry a little slack for the pin synchronisers
  task automatic near(input string nm, input int x, input int g, input int tol);
    nChecks++;
    if (g < x - tol || g > x + tol)
    begin
      $display("[FAIL] %s expected %0d seen %0d", nm, x, g);
      failures++;
    end
  endtask : near

  // ==========================================
  // register bus master
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge ref_clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge ref_clk); while (!bvalid);
    r = bresp; // bready stays high, so back-to-back calls never drive it twice at once
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    d = rdata;
    r = rresp; // rready stays high between calls
  endtask : axr

  // ==========================================
  // pin and sequence helpers
  task automatic pulse(input int n);
    syncRstN <= 1'b0;
    repeat (n) @(posedge ref_clk);
    syncRstN <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask : pulse
  // tick count at the ready fall, then realign to the clock
  task automatic fallAt(output int t);
    wait (convReadyN === 1'b1);
    @(negedge convReadyN);
    t = ticks;
    repeat (8) @(posedge ref_clk);
  endtask : fallAt
  task automatic runChop(input int first, input int steady);
    int t, f0;
    fallAt(t);
    near("first result ticks", first, t - t0, 2);
    p = chopInvert;
    f0 = nFr;
    t0 = t;
    fallAt(t);
    near("steady result ticks", steady, t - t0, 2);
    chk("polarity swap", {31'h0, ~p}, {31'h0, chopInvert});
    chk("filter resets", 32'h0000_0001, nFr - f0);
    axr(`ACD_OFS_RESULT, rv, rs);
    chk("chop mean", 32'h0000_03E8, rv);
    chk("phase cal off", 32'h0000_0001, {31'h0, phaseCalOff});
  endtask : runChop
  // osc edges until a detection fires, -1 if none within the limit
  task automatic detRun(input int lim);
    int e0, n0;
    e0 = oscEdges;
    n0 = nFall;
    while (oscEdges - e0 < lim && nFall == n0) @(posedge ref_clk);
    e = (nFall == n0) ? -1 : oscEdges - e0;
  endtask : detRun
  task automatic close_out();
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  // ==========================================
  // watchdog, well beyond the ~21k cycles the sequence needs
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    failures++;
    $display("[FAIL] watchdog expected done seen hang");
    close_out();
  end

  // ==========================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    axr(`ACD_OFS_CTRL, rv, rs);
    chk("ctrl reset", `ACD_CTRL_RST, rv);
    axr(`ACD_OFS_DET, rv, rs);
    chk("det reset", `ACD_DET_RST, rv);
    axr(8'h1C, rv, rs);
    chk("unmapped read", 32'h0000_0002, {rv[29:0], rs});
    axw(8'h1C, 32'hFFFF_FFFF, rs);
    chk("unmapped write", 32'h0000_0002, {30'h0, rs});
    axw(`ACD_OFS_CTRL, 32'hFFFF_FFFF, rs);
    axr(`ACD_OFS_CTRL, rv, rs);
    chk("ctrl mask", `ACD_CTRL_MASK, rv);
    // every power level in continuous operation
    for (int k = 0; k < 3; k++)
    begin
      axw(`ACD_OFS_CTRL, 32'h003F_3000 | (k << 8), rs);
      chk("power level", k, {30'h0, powerLevel});
      chk("phase cal on", 32'h0, {31'h0, phaseCalOff});
    end
    // chop on, then a ratio change restarts with delay code 0 and ratio 128
    axw(`ACD_OFS_CTRL, 32'h003F_3201, rs);
    axw(`ACD_OFS_CTRL, 32'h003F_0201, rs);
    t0 = ticks;
    runChop(816, 386);
    chk("power in chop", 32'h0000_0002, {30'h0, powerLevel});
    // delay code 2, restart by a short sync pulse; no detect outside standby
    axw(`ACD_OFS_DET, 32'h0000_0311, rs);
    axw(`ACD_OFS_CTRL, 32'h003F_0221, rs);
    t0 = ticks;
    pulse(3);
    chk("no detect entry", 32'h0, {31'h0, detectOscOn});
    runChop(828, 392);
    // standby keeps registers, host then stops the clock
    axw(`ACD_OFS_CMD, {16'h0, `ACD_CMD_STANDBY}, rs);
    clkRun <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("standby", 32'h0000_0002, {30'h0, standbyPowerDown, modRun});
    axr(`ACD_OFS_CTRL, rv, rs);
    chk("ctrl kept", 32'h003F_0221, rv);
    axw(`ACD_OFS_CMD, {16'h0, `ACD_CMD_WAKEUP}, rs);
    t0 = ticks;
    clkRun <= 1'b1;
    wait (modRun === 1'b1);
    near("wake ticks", 8, ticks - t0, 1);
    // detection, threshold 0x011000, two hits, all channels
    axw(`ACD_OFS_CMD, {16'h0, `ACD_CMD_STANDBY}, rs);
    clkRun <= 1'b0;
    axw(`ACD_OFS_THR_HI, 32'h0000_0001, rs);
    axw(`ACD_OFS_THR_LO, 32'h0000_1000, rs);
    detData <= {`ACD_NCH{24'h01_1000}};
    pulse(3);
    chk("detect entry", 32'h0000_0001, {31'h0, detectOscOn});
    detRun(40);
    near("equal no hit", -1, e, 0);
    detData <= {{(`ACD_NCH - 1){24'h01_1000}}, 24'hFE_EFFF};
    detRun(40);
    near("one of all", -1, e, 0);
    detData <= {{(`ACD_NCH - 1){24'h01_1001}}, 24'hFE_EFFF};
    detRun(40);
    near("all hit count", 2, e, 1);
    repeat (8) @(posedge ref_clk);
    axr(`ACD_OFS_STAT, rv, rs);
    chk("back to standby", 32'h0000_0008, rv & 32'h0000_007F);
    // any channel, one channel above
    axw(`ACD_OFS_DET, 32'h0000_0211, rs);
    detData <= {{(`ACD_NCH - 1){24'h00_0000}}, 24'h01_1001};
    pulse(3);
    detRun(40);
    near("any hit count", 2, e, 1);
    // clearing enable leaves detection; entry ignored while disabled
    pulse(3);
    axw(`ACD_OFS_DET, 32'h0000_0011, rs);
    repeat (4) @(posedge ref_clk);
    chk("detect off", 32'h0, {31'h0, detectOscOn});
    pulse(3);
    chk("entry disabled", 32'h0, {31'h0, detectOscOn});
    // long sync low resets and holds until release
    clkRun <= 1'b1;
    syncRstN <= 1'b0;
    repeat (14) @(posedge ref_clk);
    chk("held reset", 32'h0, {30'h0, standbyPowerDown, modRun});
    syncRstN <= 1'b1;
    repeat (6) @(posedge ref_clk);
    axr(`ACD_OFS_CTRL, rv, rs);
    chk("ctrl after pin reset", `ACD_CTRL_RST, rv);
    chk("running again", 32'h0000_0001, {31'h0, modRun});
    close_out();
  end
endmodule : tb_adc_chop_standby_detect_control
